// File: amc_pkg.sv
// Package for the alignment and machine-check fault unit.
// Assumes one core clock and an AXI4-Lite register bus with 32-bit data.
package amc_pkg;

	// Register byte offsets.
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_STATUS    = 8'h04;
	localparam logic [7:0] REG_MASK      = 8'h08;
	localparam logic [7:0] REG_MC_STATUS = 8'h0c;
	localparam logic [7:0] REG_MC_ADDR   = 8'h10;
	localparam logic [7:0] REG_MC_IP     = 8'h14;

	// Control register fields.
	localparam int CTRL_AM_BIT   = 0;
	localparam int CTRL_MCE_BIT  = 1;
	localparam int CTRL_PIN_BIT  = 2;
	localparam int CTRL_XGP_BIT  = 3;
	localparam logic [3:0] CTRL_RESET = 4'h4;

	// Status register fields, shared with the mask register.
	localparam int ST_AC_BIT   = 0;
	localparam int ST_GP_BIT   = 1;
	localparam int ST_MC_BIT   = 2;
	localparam int ST_SHUT_BIT = 3;
	localparam int ST_W        = 4;
	localparam logic [3:0] MASK_RESET = 4'h0;

	// Machine-check status fields.
	localparam int MCS_IPV_BIT   = 0;
	localparam int MCS_SRC_LSB   = 1;
	localparam int MCS_VALID_BIT = 3;

	// Value pushed with an alignment fault.
	localparam logic [31:0] AC_ERROR_CODE = 32'h0000_0000;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Operand kinds presented by address generation.
	typedef enum logic [3:0] {
		OP_BYTE, OP_WORD, OP_DWORD, OP_QWORD, OP_DQWORD, OP_DESC_TBL,
		OP_FPENV, OP_XSTATE, OP_UNALIGNED_DQ, OP_LEGACY_FP
	} amc_op_t;

	// Segment kinds.
	typedef enum logic [1:0] {
		SEG_DATA, SEG_STACK, SEG_CODE, SEG_SYSTEM
	} amc_seg_t;

	localparam logic [1:0] USER_LEVEL = 2'h3;

endpackage

// File: amc_sync.sv
// Two-stage synchroniser for a single level.
// Assumes the input is asynchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module amc_sync (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic d,
	output logic      q
);
	logic meta_ff;

	// The first stage is read only by the second stage.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_ff <= 1'b0;
			q       <= 1'b0;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule
`default_nettype wire

// File: amc_fault_unit.sv
// Alignment fault checker and machine-check abort dispatcher.
// Assumes the pipeline presents one checked access per valid cycle and
// that external error pins are active low and asynchronous.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Only data and stack segment accesses are checked.
// - Words need even addresses, doublewords multiples of four.
// - Descriptor-table and task register stores need four-byte alignment.
// - Floating-point environment areas need four or two bytes by size.
// - Misaligned 128-bit operands raise protection fault, not alignment fault.
// - Checking needs mask flag, check flag and user privilege together.
// - Implicit supervisor references never raise an alignment fault.
// - Misaligned descriptor-table stores at user level may fault.
// - Extended state block needs 16-byte start; fault kind is selectable.
// - Unaligned 128-bit moves check only 2, 4 and 8 byte alignment.
// - Legacy floating-point save references are checked like others.
// - Alignment fault suppresses the instruction and keeps its pointer.
// - Internal errors, bus errors and external reports raise the abort.
// - Enabled error pins load error details and raise the abort.
// - The abort pushes no error code; details go to registers.
// - Saved pointer matches the error only when pointer-valid is set.
// - The abort always changes program state; not restartable.
// - Without the enable flag a machine check enters shutdown.
module amc_fault_unit (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// Access check port from address generation.
	input  wire logic                  acc_valid,
	input  wire logic [31:0]           acc_addr,
	input  wire logic [31:0]           acc_ip,
	input  wire amc_pkg::amc_op_t      acc_op,
	input  wire amc_pkg::amc_seg_t     acc_seg,
	input  wire logic                  acc_op32,
	input  wire logic                  acc_implicit,
	input  wire logic [1:0]            current_privilege_level,
	input  wire logic                  alignment_check_flag,
	// Internal error sources.
	input  wire logic                  int_machine_err,
	input  wire logic                  int_bus_err,
	input  wire logic                  int_err_ipv,
	// External error pins, active low.
	input  wire logic                  bus_init_error_pin_n,
	input  wire logic                  machine_check_error_pin_n,
	// Fault outputs to the pipeline.
	output logic                       alignment_fault,
	output logic                       general_protection_fault,
	output logic                       suppress_commit,
	output logic [31:0]                fault_error_code,
	output logic                       fault_has_code,
	output logic [31:0]                fault_ip,
	output logic                       machine_check_abort,
	output logic                       abort_not_restartable,
	output logic                       shutdown,
	output logic                       irq,
	// AXI4-Lite slave.
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready
);
	logic [3:0]  ctrl_ff;
	logic [3:0]  status_ff;
	logic [3:0]  mask_ff;
	logic [3:0]  mc_status_ff;
	logic [31:0] mc_addr_ff;
	logic [31:0] mc_ip_ff;
	logic        aw_ff;
	logic        w_ff;
	logic [7:0]  awaddr_ff;
	logic [31:0] wdata_ff;
	logic        busy_ff;
	logic [31:0] last_addr_ff;
	logic [31:0] last_ip_ff;
	logic        bus_init_error_pin_s;
	logic        machine_check_error_pin_s;
	logic        bus_init_error_pin_q_ff;
	logic        machine_check_error_pin_q_ff;

	amc_sync u_sync_bus_init_error_pin (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (~bus_init_error_pin_n),
		.q       (bus_init_error_pin_s)
	);

	amc_sync u_sync_machine_check_error_pin (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (~machine_check_error_pin_n),
		.q       (machine_check_error_pin_s)
	);

	// Alignment check enable and operand classification.
	wire check_on   = ctrl_ff[amc_pkg::CTRL_AM_BIT] & alignment_check_flag &
	                  (current_privilege_level == amc_pkg::USER_LEVEL) &
	                  ~acc_implicit;
	wire seg_ok     = (acc_seg == amc_pkg::SEG_DATA) |
	                  (acc_seg == amc_pkg::SEG_STACK);
	wire mis2       = acc_addr[0];
	wire mis4       = |acc_addr[1:0];
	wire mis8       = |acc_addr[2:0];
	wire mis16      = |acc_addr[3:0];
	wire xgp_sel    = ctrl_ff[amc_pkg::CTRL_XGP_BIT];

	// Misalignment per operand kind, split into the two fault kinds.
	logic ac_mis;
	logic gp_mis;
	always_comb begin
		ac_mis = 1'b0;
		gp_mis = 1'b0;
		unique case (acc_op)
			amc_pkg::OP_BYTE:         ac_mis = 1'b0;
			amc_pkg::OP_WORD:         ac_mis = mis2;
			amc_pkg::OP_DWORD:        ac_mis = mis4;
			amc_pkg::OP_QWORD:        ac_mis = mis8;
			amc_pkg::OP_DQWORD:       gp_mis = mis16;
			amc_pkg::OP_DESC_TBL:     ac_mis = mis4;
			amc_pkg::OP_FPENV:        ac_mis = acc_op32 ? mis4 : mis2;
			amc_pkg::OP_XSTATE: begin
				ac_mis = mis16 & ~xgp_sel;
				gp_mis = mis16 & xgp_sel;
			end
			amc_pkg::OP_UNALIGNED_DQ: ac_mis = mis8;
			amc_pkg::OP_LEGACY_FP:    ac_mis = acc_op32 ? mis4 : mis2;
			default: begin
				ac_mis = 1'b0;
				gp_mis = 1'b0;
			end
		endcase
	end

	// The 128-bit protection check does not depend on alignment enabling.
	wire ac_hit = acc_valid & seg_ok & check_on & ac_mis;
	wire gp_hit = acc_valid & seg_ok & gp_mis &
	              ((acc_op == amc_pkg::OP_DQWORD) | check_on);

	// Machine-check sources; pins count only while enabled.
	wire pin_en  = ctrl_ff[amc_pkg::CTRL_PIN_BIT];
	wire pin_evt = pin_en & ((bus_init_error_pin_s & ~bus_init_error_pin_q_ff) |
	                         (machine_check_error_pin_s & ~machine_check_error_pin_q_ff));
	wire mc_evt  = int_machine_err | int_bus_err | pin_evt;
	wire mce_on  = ctrl_ff[amc_pkg::CTRL_MCE_BIT];
	wire [1:0] mc_src = int_machine_err ? 2'h1 : (int_bus_err ? 2'h2 : 2'h3);

	// Fault outputs to the pipeline, one cycle after the access.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alignment_fault          <= 1'b0;
			general_protection_fault <= 1'b0;
			suppress_commit          <= 1'b0;
			fault_error_code         <= 32'h0000_0000;
			fault_has_code           <= 1'b0;
			fault_ip                 <= 32'h0000_0000;
			bus_init_error_pin_q_ff               <= 1'b0;
			machine_check_error_pin_q_ff               <= 1'b0;
		end else begin
			bus_init_error_pin_q_ff               <= bus_init_error_pin_s;
			machine_check_error_pin_q_ff               <= machine_check_error_pin_s;
			alignment_fault          <= ac_hit & ~gp_hit;
			general_protection_fault <= gp_hit;
			suppress_commit          <= ac_hit | gp_hit;
			fault_error_code         <= amc_pkg::AC_ERROR_CODE;
			fault_has_code           <= (ac_hit | gp_hit) & ~mc_evt;
			fault_ip                 <= acc_ip;
		end
	end

	// Track the last access pointer to associate with machine checks.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_addr_ff <= 32'h0000_0000;
			last_ip_ff   <= 32'h0000_0000;
		end else if (acc_valid) begin
			last_addr_ff <= acc_addr;
			last_ip_ff   <= acc_ip;
		end
	end

	// Abort and shutdown; shutdown is sticky until reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			machine_check_abort   <= 1'b0;
			abort_not_restartable <= 1'b0;
			shutdown              <= 1'b0;
		end else begin
			machine_check_abort   <= mc_evt & mce_on & ~shutdown;
			abort_not_restartable <= mc_evt & mce_on & ~shutdown;
			if (mc_evt & ~mce_on)
				shutdown <= 1'b1;
		end
	end

	// Bus write decode.
	wire wr_go  = aw_ff & w_ff & ~s_axi_bvalid;
	wire wr_ctl = wr_go & (awaddr_ff == amc_pkg::REG_CTRL);
	wire wr_st  = wr_go & (awaddr_ff == amc_pkg::REG_STATUS);
	wire wr_msk = wr_go & (awaddr_ff == amc_pkg::REG_MASK);
	wire wr_mcs = wr_go & (awaddr_ff == amc_pkg::REG_MC_STATUS);
	wire wr_ok  = wr_ctl | wr_st | wr_msk | wr_mcs;
	wire [3:0] st_clr = wr_st ? wdata_ff[3:0] : 4'h0;
	wire [3:0] st_set = {mc_evt & ~mce_on, mc_evt & mce_on, gp_hit,
	                     ac_hit & ~gp_hit};

	// Control, mask and sticky status; a new event wins over a clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff   <= amc_pkg::CTRL_RESET;
			mask_ff   <= amc_pkg::MASK_RESET;
			status_ff <= 4'h0;
		end else begin
			if (wr_ctl)
				ctrl_ff <= wdata_ff[3:0];
			if (wr_msk)
				mask_ff <= wdata_ff[3:0];
			status_ff <= (status_ff & ~st_clr) | st_set;
		end
	end

	// Machine-check registers capture each new error, overwriting the previous one.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mc_status_ff <= 4'h0;
			mc_addr_ff   <= 32'h0000_0000;
			mc_ip_ff     <= 32'h0000_0000;
		end else if (mc_evt) begin
			mc_status_ff <= {1'b1, mc_src, int_err_ipv & ~pin_evt};
			mc_addr_ff   <= last_addr_ff;
			mc_ip_ff     <= last_ip_ff;
		end else if (wr_mcs) begin
			mc_status_ff <= wdata_ff[3:0];
		end
	end

	assign irq = |(status_ff & mask_ff);

	// Write channel handshake; address and data in either order.
	assign s_axi_awready = ~aw_ff;
	assign s_axi_wready  = ~w_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ff        <= 1'b0;
			w_ff         <= 1'b0;
			awaddr_ff    <= 8'h00;
			wdata_ff     <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= amc_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid & ~aw_ff) begin
				aw_ff     <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid & ~w_ff) begin
				w_ff     <= 1'b1;
				wdata_ff <= s_axi_wdata;
			end
			if (wr_go) begin
				aw_ff        <= 1'b0;
				w_ff         <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? amc_pkg::RESP_OKAY :
				                        amc_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read decode; unmapped addresses answer with a slave error.
	logic [31:0] rd_mux;
	logic        rd_ok;
	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_ok  = 1'b1;
		unique case (s_axi_araddr)
			amc_pkg::REG_CTRL:      rd_mux = {28'h0, ctrl_ff};
			amc_pkg::REG_STATUS:    rd_mux = {28'h0, status_ff};
			amc_pkg::REG_MASK:      rd_mux = {28'h0, mask_ff};
			amc_pkg::REG_MC_STATUS: rd_mux = {28'h0, mc_status_ff};
			amc_pkg::REG_MC_ADDR:   rd_mux = mc_addr_ff;
			amc_pkg::REG_MC_IP:     rd_mux = mc_ip_ff;
			default:                rd_ok  = 1'b0;
		endcase
	end

	assign s_axi_arready = ~busy_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_ff      <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= amc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid & ~busy_ff) begin
			busy_ff      <= 1'b1;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_ok ? amc_pkg::RESP_OKAY : amc_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid & s_axi_rready) begin
			busy_ff      <= 1'b0;
			s_axi_rvalid <= 1'b0;
		end
	end

	// A misaligned user word access in a data segment must produce the fault with zero code.
	chk_ac_raise: assert property (@(posedge aclk) disable iff (!aresetn)
		acc_valid && acc_op == amc_pkg::OP_WORD && acc_addr[0] &&
		acc_seg == amc_pkg::SEG_DATA && check_on
		|=> alignment_fault && fault_error_code == 32'h0)
		else $error("misaligned word did not fault");

	chk_code_seg: assert property (@(posedge aclk) disable iff (!aresetn)
		acc_valid && acc_seg == amc_pkg::SEG_CODE |=> !alignment_fault)
		else $error("code segment access faulted");

	chk_priv_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		current_privilege_level != 2'h3 |=> !alignment_fault)
		else $error("fault outside user level");

	chk_implicit_ref: assert property (@(posedge aclk) disable iff (!aresetn)
		acc_implicit |=> !alignment_fault)
		else $error("implicit reference faulted");

	chk_dq_gp: assert property (@(posedge aclk) disable iff (!aresetn)
		acc_valid && acc_op == amc_pkg::OP_DQWORD && acc_addr[3:0] != 4'h0 &&
		seg_ok |=> general_protection_fault && !alignment_fault)
		else $error("128-bit misalignment missed protection fault");

	chk_udq_nogp: assert property (@(posedge aclk) disable iff (!aresetn)
		acc_valid && acc_op == amc_pkg::OP_UNALIGNED_DQ
		|=> !general_protection_fault)
		else $error("unaligned move raised protection fault");

	chk_fault_ip: assert property (@(posedge aclk) disable iff (!aresetn)
		ac_hit |=> suppress_commit && fault_ip == $past(acc_ip))
		else $error("fault pointer or suppression wrong");

	chk_mc_abort: assert property (@(posedge aclk) disable iff (!aresetn)
		mc_evt && mce_on && !shutdown |=> machine_check_abort &&
		!fault_has_code && mc_status_ff[amc_pkg::MCS_VALID_BIT])
		else $error("machine check not dispatched");

	chk_mc_shut: assert property (@(posedge aclk) disable iff (!aresetn)
		mc_evt && !mce_on |=> shutdown && !machine_check_abort)
		else $error("disabled machine check did not shut down");

	chk_pin_load: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(machine_check_error_pin_n) && pin_en && mce_on && !shutdown &&
		!int_machine_err && !int_bus_err
		|-> ##[3:4] machine_check_abort)
		else $error("error pin did not raise abort");

endmodule
`default_nettype wire

// File: amc_err_agent.sv
// Model of the external agents that report bus errors on the two pins.
// Assumes the bench requests a report with a one-cycle pulse on aclk.
`timescale 1ns/1ps
`default_nettype none
module amc_err_agent #(
	parameter int HOLD = 3
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic fire_init,
	input  wire logic fire_mc,
	output logic      bus_init_error_pin_n,
	output logic      machine_check_error_pin_n
);
	logic [3:0] init_cnt_ff;
	logic [3:0] mc_cnt_ff;

	// Each request holds its pin low for HOLD cycles, then the pull-up wins.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			init_cnt_ff <= 4'h0;
			mc_cnt_ff   <= 4'h0;
		end else begin
			init_cnt_ff <= fire_init ? 4'(HOLD) :
			               init_cnt_ff - 4'(init_cnt_ff != 4'h0);
			mc_cnt_ff   <= fire_mc ? 4'(HOLD) :
			               mc_cnt_ff - 4'(mc_cnt_ff != 4'h0);
		end
	end

	// Pins are active low and released high between reports.
	assign bus_init_error_pin_n      = (init_cnt_ff == 4'h0);
	assign machine_check_error_pin_n = (mc_cnt_ff == 4'h0);
endmodule
`default_nettype wire

// File: alignment_and_machine_check_faults_tb.sv
// Self-checking bench for the alignment and machine-check fault unit.
// Assumes the unit and the error agent model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module alignment_and_machine_check_faults_tb;
	logic aclk = 1'b0;
	logic aresetn, acc_valid, acc_op32, acc_implicit, alignment_check_flag;
	logic [31:0] acc_addr, acc_ip, s_axi_wdata, s_axi_rdata, lfsr, r, rd;
	amc_pkg::amc_op_t acc_op;
	amc_pkg::amc_seg_t acc_seg;
	logic [1:0] current_privilege_level, s_axi_bresp, s_axi_rresp, pe, ef, rsp;
	logic int_machine_err, int_bus_err, int_err_ipv, fire_init, fire_mc;
	logic pin_init_n, pin_mc_n, alignment_fault, general_protection_fault;
	logic suppress_commit, fault_has_code, machine_check_abort, irq;
	logic abort_not_restartable, shutdown, pend, seen, any_f;
	logic [31:0] fault_error_code, fault_ip, pip;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [3:0] s_axi_wstrb, ctrl;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	int miscompares, check_count, cyc;

	amc_fault_unit u_dut (.aclk(aclk), .aresetn(aresetn), .acc_valid(acc_valid),
		.acc_addr(acc_addr), .acc_ip(acc_ip), .acc_op(acc_op), .acc_seg(acc_seg),
		.acc_op32(acc_op32), .acc_implicit(acc_implicit),
		.current_privilege_level(current_privilege_level),
		.alignment_check_flag(alignment_check_flag),
		.int_machine_err(int_machine_err), .int_bus_err(int_bus_err),
		.int_err_ipv(int_err_ipv), .bus_init_error_pin_n(pin_init_n),
		.machine_check_error_pin_n(pin_mc_n), .alignment_fault(alignment_fault),
		.general_protection_fault(general_protection_fault),
		.suppress_commit(suppress_commit), .fault_error_code(fault_error_code),
		.fault_has_code(fault_has_code), .fault_ip(fault_ip),
		.machine_check_abort(machine_check_abort),
		.abort_not_restartable(abort_not_restartable), .shutdown(shutdown),
		.irq(irq), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));

	amc_err_agent u_agent (.aclk(aclk), .aresetn(aresetn), .fire_init(fire_init),
		.fire_mc(fire_mc), .bus_init_error_pin_n(pin_init_n),
		.machine_check_error_pin_n(pin_mc_n));

	// The clock runs at 10 MHz.
	always #50 aclk = ~aclk;

	// A hang is cut short well past the expected length of the run.
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
		check_count++;
		if (seen_v !== exp_v) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
		end
	endtask

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Expected {protection, alignment} fault for one access.
	function automatic logic [1:0] exp_fault(input amc_pkg::amc_op_t op,
		input amc_pkg::amc_seg_t sg, input logic [31:0] a, input logic o32,
		input logic imp, input logic [1:0] pl, input logic acf,
		input logic [3:0] c);
		logic en;
		logic [3:0] m;
		en = c[0] && acf && pl == amc_pkg::USER_LEVEL && !imp &&
			(sg == amc_pkg::SEG_DATA || sg == amc_pkg::SEG_STACK);
		case (op)
			amc_pkg::OP_WORD: m = a[3:0] & 4'h1;
			amc_pkg::OP_DWORD, amc_pkg::OP_DESC_TBL: m = a[3:0] & 4'h3;
			amc_pkg::OP_QWORD, amc_pkg::OP_UNALIGNED_DQ: m = a[3:0] & 4'h7;
			amc_pkg::OP_FPENV, amc_pkg::OP_LEGACY_FP: m = a[3:0] & (o32 ? 4'h3 : 4'h1);
			amc_pkg::OP_XSTATE: m = a[3:0];
			default: m = 4'h0;
		endcase
		if (op == amc_pkg::OP_DQWORD)
			return {a[3:0] != 4'h0, 1'b0};
		if (op == amc_pkg::OP_XSTATE && c[3])
			return {en && m != 4'h0, 1'b0};
		return {1'b0, en && m != 4'h0};
	endfunction

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// One internal error pulse; returns after the edge that samples it.
	task automatic pulse_err(input logic mach, input logic ipv);
		@(posedge aclk);
		int_machine_err <= mach;
		int_bus_err <= !mach;
		int_err_ipv <= ipv;
		@(posedge aclk);
		int_machine_err <= 1'b0;
		int_bus_err <= 1'b0;
		#1;
	endtask

	// Waits a few cycles and notes whether the abort pulsed.
	task automatic watch_abort();
		seen = 1'b0;
		repeat (8) begin
			@(posedge aclk);
			#1;
			if (machine_check_abort === 1'b1) seen = 1'b1;
		end
	endtask

	initial begin
		{aresetn, acc_valid, acc_op32, acc_implicit, alignment_check_flag} = '0;
		{acc_addr, acc_ip, s_axi_wdata, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{int_machine_err, int_bus_err, int_err_ipv, fire_init, fire_mc} = '0;
		acc_op = amc_pkg::OP_BYTE;
		acc_seg = amc_pkg::SEG_DATA;
		current_privilege_level = 2'h0;
		s_axi_wstrb = 4'hf;
		lfsr = 32'hfd5e;
		any_f = 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		// Reset values, then an unmapped address.
		axi_read(amc_pkg::REG_CTRL);
		check(rd, 32'h4);
		axi_read(amc_pkg::REG_MASK);
		check(rd, 32'h0);
		axi_read(8'h20);
		check(32'(rsp), 32'(amc_pkg::RESP_SLVERR));
		$display("test registers done");
		// Random back-to-back accesses under each mask and fault-kind setting.
		for (int ph = 0; ph < 4; ph++) begin
			ctrl = {ph[1], 2'b10, ph[0]};
			axi_write(amc_pkg::REG_CTRL, 32'(ctrl));
			pend = 1'b0;
			for (int i = 0; i < 61; i++) begin
				@(posedge aclk);
				lfsr = lfsr_next(lfsr);
				r = lfsr;
				acc_valid <= (i < 60);
				acc_addr <= r;
				acc_ip <= {r[15:0], r[31:16]};
				acc_op <= amc_pkg::amc_op_t'(4'(r[19:16] % 4'ha));
				acc_seg <= (4'(r[19:16] % 4'ha) == 4'h4) ? amc_pkg::SEG_DATA :
					amc_pkg::amc_seg_t'(r[10:9]);
				acc_op32 <= r[13];
				acc_implicit <= r[11] & r[12] & (4'(r[19:16] % 4'ha) != 4'h4);
				current_privilege_level <= r[5:4] | {2{r[6]}};
				alignment_check_flag <= r[7] | r[8];
				#1;
				ef = exp_fault(acc_op, acc_seg, acc_addr, acc_op32, acc_implicit,
					current_privilege_level, alignment_check_flag, ctrl);
				if (pend) begin
					check(32'(alignment_fault), 32'(pe[0]));
					check(32'(general_protection_fault), 32'(pe[1]));
					check(32'(suppress_commit), 32'(|pe));
					check(32'(fault_has_code), 32'(|pe));
					check(fault_error_code, 32'h0);
					if (|pe) check(fault_ip, pip);
				end
				pend = (i < 60);
				pe = ef;
				pip = acc_ip;
				any_f = any_f | (pend & (|ef));
			end
		end
		// A misaligned user word in a data segment must fault and keep its pointer.
		@(posedge aclk);
		acc_valid <= 1'b1;
		acc_addr <= 32'h0000_1001;
		acc_ip <= 32'h0000_0abc;
		acc_op <= amc_pkg::OP_WORD;
		acc_seg <= amc_pkg::SEG_DATA;
		acc_implicit <= 1'b0;
		current_privilege_level <= amc_pkg::USER_LEVEL;
		alignment_check_flag <= 1'b1;
		@(posedge aclk);
		acc_valid <= 1'b0;
		#1;
		check(32'(alignment_fault), 32'h1);
		check(fault_ip, 32'h0000_0abc);
		any_f = 1'b1;
		$display("test alignment done");
		// Sticky status, mask and clear drive the interrupt.
		check(32'(irq), 32'h0);
		axi_write(amc_pkg::REG_MASK, 32'h3);
		#1;
		check(32'(irq), 32'(any_f));
		axi_write(amc_pkg::REG_STATUS, 32'hf);
		check(32'(rsp), 32'(amc_pkg::RESP_OKAY));
		#1;
		check(32'(irq), 32'h0);
		$display("test interrupt done");
		// Internal errors with the abort enabled.
		axi_write(amc_pkg::REG_CTRL, 32'h6);
		axi_write(amc_pkg::REG_MASK, 32'h4);
		@(posedge aclk);
		acc_valid <= 1'b1;
		acc_addr <= 32'h40;
		acc_ip <= 32'h1234;
		acc_op <= amc_pkg::OP_BYTE;
		@(posedge aclk);
		acc_valid <= 1'b0;
		pulse_err(1'b1, 1'b1);
		check(32'(machine_check_abort), 32'h1);
		check(32'(abort_not_restartable), 32'h1);
		check(32'(fault_has_code), 32'h0);
		axi_read(amc_pkg::REG_MC_STATUS);
		check(rd, 32'hb);
		axi_read(amc_pkg::REG_MC_IP);
		check(rd, 32'h1234);
		axi_read(amc_pkg::REG_MC_ADDR);
		check(rd, 32'h40);
		check(32'(irq), 32'h1);
		pulse_err(1'b0, 1'b0);
		check(32'(machine_check_abort), 32'h1);
		axi_read(amc_pkg::REG_MC_STATUS);
		check(rd, 32'hc);
		// Both error pins enabled, then the machine-check pin with pins disabled.
		for (int k = 0; k < 2; k++) begin
			@(posedge aclk);
			fire_init <= (k == 0);
			fire_mc <= (k == 1);
			@(posedge aclk);
			{fire_init, fire_mc} <= 2'b00;
			watch_abort();
			check(32'(seen), 32'h1);
			axi_read(amc_pkg::REG_MC_STATUS);
			check(rd, 32'he);
		end
		axi_write(amc_pkg::REG_CTRL, 32'h2);
		@(posedge aclk);
		fire_mc <= 1'b1;
		@(posedge aclk);
		fire_mc <= 1'b0;
		watch_abort();
		check(32'(seen), 32'h0);
		axi_read(amc_pkg::REG_MC_STATUS);
		check(rd, 32'he);
		axi_write(amc_pkg::REG_MC_STATUS, 32'h0);
		check(32'(rsp), 32'(amc_pkg::RESP_OKAY));
		axi_read(amc_pkg::REG_MC_STATUS);
		check(rd, 32'h0);
		$display("test machine check done");
		// With the enable flag clear a machine check shuts the core down.
		axi_write(amc_pkg::REG_CTRL, 32'h4);
		pulse_err(1'b1, 1'b0);
		check(32'(machine_check_abort), 32'h0);
		check(32'(shutdown), 32'h1);
		repeat (3) @(posedge aclk);
		check(32'(shutdown), 32'h1);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		#1;
		check(32'(shutdown), 32'h0);
		$display("test shutdown done");
		print_verdict();
	end
endmodule
`default_nettype wire
